// [rtl/e3lmr_pkg.sv]
/*
  e3lmr_pkg: constants, field positions, codes and state types for the
  e3 link message receiver. Assumes a 100 MHz aclk and AXI4-Lite access.
*/
package e3lmr_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0]  CTRL_IDX       = 10'h018;
  localparam logic [9:0]  STAT_IDX       = 10'h019;
  localparam int          ADDR_W         = 12;
  // message buffer window, one byte per aligned word
  localparam logic [11:0] BUF_BASE       = 12'h0400;
  localparam int          BUF_AW         = 7;
  localparam logic [6:0]  BUF_DEPTH      = 7'h52;
  // control register fields
  localparam int          CTRL_EN_BIT    = 2;
  localparam int          CTRL_IE_BIT    = 1;
  localparam int          CTRL_IS_BIT    = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  STAT_RESET     = 8'h00;
  // frame layout
  localparam logic [7:0]  FLAG_OCTET     = 8'h7E;
  localparam logic [7:0]  HDR_OCTETS     = 8'h03;
  localparam logic [7:0]  CR_OCTET_IDX   = 8'h00;
  localparam int          CR_BIT         = 1;
  localparam logic [7:0]  MIN_OCTETS     = 8'h05;
  localparam logic [2:0]  ONES_STUFF     = 3'h5;
  localparam logic [2:0]  ONES_FLAG      = 3'h6;
  localparam logic [2:0]  FLAG_BITS_HELD = 3'h7;
  // frame check
  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  // message type octets and kind codes
  localparam logic [7:0]  TYPE_TEST      = 8'h32;
  localparam logic [7:0]  TYPE_IDLE      = 8'h34;
  localparam logic [7:0]  TYPE_CL        = 8'h38;
  localparam logic [7:0]  TYPE_ITU       = 8'h3F;
  localparam logic [1:0]  KIND_TEST      = 2'h0;
  localparam logic [1:0]  KIND_IDLE      = 2'h1;
  localparam logic [1:0]  KIND_CL        = 2'h2;
  localparam logic [1:0]  KIND_ITU       = 2'h3;
  // bus answers
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {
    RX_HUNT  = 3'b001,
    RX_IDLE  = 3'b010,
    RX_FRAME = 3'b100
  } e3lmr_rx_state_t;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_MEM  = 3'b010,
    RD_CAP  = 3'b100
  } e3lmr_rd_state_t;

  typedef enum logic [1:0] {
    DEC_NONE = 2'h0,
    DEC_CTRL = 2'h1,
    DEC_STAT = 2'h2,
    DEC_BUF  = 2'h3
  } e3lmr_dec_t;
endpackage : e3lmr_pkg

// [rtl/e3lmr_buf_if.sv]
/*
  e3lmr_buf_if: write and read port bundle of the message buffer.
  Assumes both ends run on the same aclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface e3lmr_buf_if;
  logic       wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  modport fill  (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : e3lmr_buf_if
`default_nettype wire

// [rtl/e3lmr_msg_mem.sv]
/*
  e3lmr_msg_mem: byte store for the received information field, one write
  and one registered read port. Assumes addresses beyond depth are dropped.
*/
`timescale 1ns/100ps
`default_nettype none
module e3lmr_msg_mem
  import e3lmr_pkg::*;
(
  input  wire logic    aclk,
  e3lmr_buf_if.store   buf_port
);
  logic [7:0] mem_q [0:81];
  logic [7:0] rd_data_q;

  // write port, out-of-range addresses ignored
  always_ff @(posedge aclk)
  begin
    if (buf_port.wr_en && (buf_port.wr_addr < BUF_DEPTH))
    begin
      mem_q[buf_port.wr_addr] <= buf_port.wr_data;
    end
  end

  // read data leaves through a register; no reset on the array itself
  always_ff @(posedge aclk)
  begin
    if (buf_port.rd_addr < BUF_DEPTH)
    begin
      rd_data_q <= mem_q[buf_port.rd_addr];
    end
    else
    begin
      rd_data_q <= 8'h00;
    end
  end

  assign buf_port.rd_data = rd_data_q;
endmodule : e3lmr_msg_mem
`default_nettype wire

// [rtl/e3lmr_rx.sv]
/*
  e3lmr_rx: e3 link message receiver. Hunts the N overhead bit stream for
  flags, removes stuffed zeros, stores the information field, checks the
  frame check sequence and reports status over AXI4-Lite.
  Assumes rx_n_strobe pulses once per inbound frame with rx_n_bit steady
  around it; both come from the line side and are synchronised here.
*/
// Operation
// - while enabled, collect the N bit of each frame and hunt for 0x7E flags
// - a recognised flag sets status bit 0, delimiters and idle fill alike
// - status bit 0 clears on the first octet that is not a flag
// - seven or more ones after a flag are an abort; status bit 6 set
// - a non-flag, non-abort octet after a flag starts frame reassembly
// - frame: flag, address, endpoint id, control, 76/82 info, check hi/lo, flag
// - the check is a 16-bit crc with polynomial x16+x12+x5+1
// - first info byte gives type: 0x38, 0x34, 0x32 are 76 bytes, 0x3F 82
// - a zero right after five ones is deleted before storing
// - crc over header and info octets is compared with the received check
// - status bit 2 set on mismatch, cleared on match
// - the info field is stored whether or not the check passed
// - after each frame the address octet c/r bit is copied to status bit 3
// - status bit 3 reads 0 for customer side, 1 for network side
// - status bits 5:4 give the kind: 00 test, 01 idle, 10 cl, 11 itu
// - a fully processed frame sets message complete, status bit 1
// - a processed frame sets control bit 0, cleared on read, irq if enabled
`timescale 1ns/100ps
`default_nettype none
module e3lmr_rx
  import e3lmr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              rx_n_bit,
  input  wire logic              rx_n_strobe,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   rx_msg_irq
);
  e3lmr_buf_if buf_bus ();

  e3lmr_msg_mem u_mem (
    .aclk     (aclk),
    .buf_port (buf_bus.store)
  );

  // address decode shared by the read and write paths
  function automatic e3lmr_dec_t e3lmr_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - BUF_BASE;
    if (a[1:0] != 2'b00)
      return DEC_NONE;
    else if (a[ADDR_W-1:2] == CTRL_IDX)
      return DEC_CTRL;
    else if (a[ADDR_W-1:2] == STAT_IDX)
      return DEC_STAT;
    else if ((a >= BUF_BASE) && (off[ADDR_W-1:2] < {3'b000, BUF_DEPTH}))
      return DEC_BUF;
    else
      return DEC_NONE;
  endfunction : e3lmr_decode

  // one octet into the msb-first crc register
  function automatic logic [15:0] e3lmr_crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[15] ^ b[i])
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      else
        r = {r[14:0], 1'b0};
    end
    return r;
  endfunction : e3lmr_crc_byte

  // type octet to kind code; unknown types read as test
  function automatic logic [1:0] e3lmr_kind(input logic [7:0] t);
    unique case (t)
      TYPE_IDLE: return KIND_IDLE;
      TYPE_CL:   return KIND_CL;
      TYPE_ITU:  return KIND_ITU;
      default:   return KIND_TEST;
    endcase
  endfunction : e3lmr_kind

  e3lmr_rx_state_t rx_state_q;
  e3lmr_rd_state_t rd_state_q;
  logic        bit_s1_q, bit_s2_q, stb_s1_q, stb_s2_q, stb_s3_q;
  logic [2:0]  ones_q;
  logic [6:0]  dly_q;
  logic [2:0]  dly_fill_q;
  logic [7:0]  oct_q;
  logic [2:0]  bcnt_q;
  logic [7:0]  hold0_q, hold1_q, oct_total_q;
  logic [15:0] crc_q;
  logic        cr_frame_q;
  logic [1:0]  kind_frame_q;
  logic        en_q, ie_q, is_q;
  logic        flag_q, done_q, err_q, cr_q, abort_q;
  logic [1:0]  kind_q;
  logic        aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic        bit_take, bit_in, flag_hit, abort_hit, stuff_drop, data_bit;
  logic        asm_bit, asm_push, oct_done, emit;
  logic [7:0]  oct_new, emit_idx, info_idx;
  logic        frame_end, publish, do_write, ar_take, ctrl_read;
  e3lmr_dec_t  wr_dec;

  // two-flop synchronisers; strobe edge taken from the second and third stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bit_s1_q <= 1'b0;
      bit_s2_q <= 1'b0;
      stb_s1_q <= 1'b0;
      stb_s2_q <= 1'b0;
      stb_s3_q <= 1'b0;
    end
    else
    begin
      bit_s1_q <= rx_n_bit;
      bit_s2_q <= bit_s1_q;
      stb_s1_q <= rx_n_strobe;
      stb_s2_q <= stb_s1_q;
      stb_s3_q <= stb_s2_q;
    end
  end

  // bit classification on the raw stream
  assign bit_in     = bit_s2_q;
  assign bit_take   = stb_s2_q && !stb_s3_q && en_q;
  assign flag_hit   = bit_take && !bit_in && (ones_q == ONES_FLAG);
  assign abort_hit  = bit_take && bit_in && (ones_q == ONES_FLAG) && !rx_state_q[0];
  assign stuff_drop = bit_take && !bit_in && (ones_q == ONES_STUFF);
  assign data_bit   = bit_take && !flag_hit && !abort_hit && !stuff_drop && !rx_state_q[0];

  // the last seven data bits are held back: at a flag they are its own bits
  assign asm_bit  = dly_q[0];
  assign asm_push = data_bit && (dly_fill_q == FLAG_BITS_HELD);
  assign oct_new  = {asm_bit, oct_q[7:1]};
  assign oct_done = asm_push && (bcnt_q == 3'h7);

  // octets run two behind so the check octets never reach the crc
  assign emit      = oct_done && rx_state_q[2] && (oct_total_q >= 8'h02);
  assign emit_idx  = oct_total_q - 8'h02;
  assign info_idx  = emit_idx - HDR_OCTETS;
  assign frame_end = flag_hit && rx_state_q[2];
  assign publish   = frame_end && (oct_total_q >= MIN_OCTETS);

  // ones run length, kept through the whole stream
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en_q)
      ones_q <= 3'h0;
    else if (bit_take)
      ones_q <= !bit_in ? 3'h0 : ((ones_q == ONES_FLAG) ? ones_q : ones_q + 3'h1);
  end

  // delay line and octet assembler, lsb first; a flag or abort restarts both
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en_q || flag_hit || abort_hit)
    begin
      dly_q      <= 7'h00;
      dly_fill_q <= 3'h0;
      oct_q      <= 8'h00;
      bcnt_q     <= 3'h0;
    end
    else if (data_bit)
    begin
      dly_q      <= {bit_in, dly_q[6:1]};
      dly_fill_q <= asm_push ? dly_fill_q : dly_fill_q + 3'h1;
      if (asm_push)
      begin
        oct_q  <= oct_new;
        bcnt_q <= bcnt_q + 3'h1;
      end
    end
  end

  // receive sequencing: hunt, between frames, inside a frame
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en_q)
      rx_state_q <= RX_HUNT;
    else
    begin
      unique case (rx_state_q)
        RX_HUNT:  if (flag_hit) rx_state_q <= RX_IDLE;
        RX_IDLE:
        begin
          if (abort_hit)
            rx_state_q <= RX_HUNT;
          else if (oct_done)
            rx_state_q <= RX_FRAME;
        end
        RX_FRAME:
        begin
          if (abort_hit)
            rx_state_q <= RX_HUNT;
          else if (flag_hit)
            rx_state_q <= RX_IDLE;   // closing flag may open the next frame
        end
        default: rx_state_q <= RX_HUNT;
      endcase
    end
  end

  // frame octet pipeline, crc and per-frame captures
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (rx_state_q != RX_FRAME))
    begin
      hold0_q      <= oct_new;
      hold1_q      <= 8'h00;
      oct_total_q  <= (oct_done && rx_state_q[1]) ? 8'h01 : 8'h00;
      crc_q        <= CRC_INIT;
      cr_frame_q   <= 1'b0;
      kind_frame_q <= KIND_TEST;
    end
    else if (oct_done)
    begin
      hold0_q     <= oct_new;
      hold1_q     <= hold0_q;
      oct_total_q <= (oct_total_q == 8'hFF) ? oct_total_q : oct_total_q + 8'h01;
      if (emit)
      begin
        crc_q <= e3lmr_crc_byte(crc_q, hold1_q);
        if (emit_idx == CR_OCTET_IDX)
          cr_frame_q <= hold1_q[CR_BIT];
        if (emit_idx == HDR_OCTETS)
          kind_frame_q <= e3lmr_kind(hold1_q);
      end
    end
  end

  // information bytes go to the buffer regardless of the check outcome
  assign buf_bus.wr_en   = emit && (emit_idx >= HDR_OCTETS) &&
                           (info_idx < {1'b0, BUF_DEPTH});
  assign buf_bus.wr_addr = info_idx[BUF_AW-1:0];
  assign buf_bus.wr_data = hold1_q;

  // flag present and abort seen
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_q  <= STAT_RESET[0];
      abort_q <= STAT_RESET[6];
    end
    else
    begin
      if (flag_hit)
        flag_q <= 1'b1;
      else if (asm_push || abort_hit)
        flag_q <= 1'b0;   // eighth data bit: not a flag
      if (abort_hit)
        abort_q <= 1'b1;
      else if (oct_done && rx_state_q[1])
        abort_q <= 1'b0;   // a new frame starting retires the old abort
    end
  end

  // per-frame results published together at the closing flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_q <= STAT_RESET[1];
      err_q  <= STAT_RESET[2];
      cr_q   <= STAT_RESET[3];
      kind_q <= STAT_RESET[5:4];
    end
    else if (publish)
    begin
      done_q <= 1'b1;
      err_q  <= (crc_q != {hold1_q, hold0_q});
      cr_q   <= cr_frame_q;
      kind_q <= kind_frame_q;
    end
  end

  // control register; the status event wins over a clearing read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_q <= CTRL_RESET[CTRL_EN_BIT];
      ie_q <= CTRL_RESET[CTRL_IE_BIT];
      is_q <= CTRL_RESET[CTRL_IS_BIT];
    end
    else
    begin
      if (do_write && (wr_dec == DEC_CTRL) && wstrb_q[0])
      begin
        en_q <= wdata_q[CTRL_EN_BIT];
        ie_q <= wdata_q[CTRL_IE_BIT];
      end
      if (publish)
        is_q <= 1'b1;
      else if (ctrl_read)
        is_q <= 1'b0;
    end
  end

  assign rx_msg_irq = is_q && ie_q;

  // write channel: address and data taken in either order
  assign wr_dec        = e3lmr_decode(awaddr_q);
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign do_write      = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_dec == DEC_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // read channel: one spare cycle lets the buffer's registered data settle
  assign s_axi_arready   = (rd_state_q == RD_IDLE) && !rvalid_q;
  assign ar_take         = s_axi_arvalid && s_axi_arready;
  assign ctrl_read       = (rd_state_q == RD_CAP) && (e3lmr_decode(araddr_q) == DEC_CTRL);
  assign buf_bus.rd_addr = araddr_q[BUF_AW+1:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_q <= RD_IDLE;
      araddr_q   <= '0;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= RESP_OKAY;
    end
    else
    begin
      unique case (rd_state_q)
        RD_IDLE: if (ar_take)
        begin
          araddr_q   <= s_axi_araddr;
          rd_state_q <= RD_MEM;
        end
        RD_MEM: rd_state_q <= RD_CAP;
        RD_CAP:
        begin
          rd_state_q <= RD_IDLE;
          rvalid_q   <= 1'b1;
          rresp_q    <= RESP_OKAY;
          unique case (e3lmr_decode(araddr_q))
            DEC_CTRL: rdata_q <= {29'h0000_0000, en_q, ie_q, is_q};
            DEC_STAT: rdata_q <= {25'h000_0000, abort_q, kind_q, cr_q, err_q, done_q, flag_q};
            DEC_BUF:  rdata_q <= {24'h00_0000, buf_bus.rd_data};
            DEC_NONE:
            begin
              rdata_q <= 32'h0000_0000;
              rresp_q <= RESP_SLVERR;
            end
          endcase
        end
        default: rd_state_q <= RD_IDLE;
      endcase
      if (rvalid_q && s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;
endmodule : e3lmr_rx
`default_nettype wire

// [sim/e3lmr_rx_assertions.sv]
/*
  e3lmr_rx_assertions: bus and interrupt checks on the receiver's ports.
  Assumes one aclk domain and a synchronous active-low aresetn.
*/
`timescale 1ns/100ps
`default_nettype none
module e3lmr_rx_assertions
  import e3lmr_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              rx_msg_irq
);
  logic rd_bad_q;
  logic rd_stat_q;
  logic rd_ctrl_q;
  default clocking cb @(posedge aclk); endclocking
  // remember what the read in flight addresses; its answer comes later
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
    begin
      rd_ctrl_q <= s_axi_araddr == 12'h060;
      rd_stat_q <= s_axi_araddr == 12'h064;
      rd_bad_q  <= !(s_axi_araddr == 12'h060 || s_axi_araddr == 12'h064 ||
                     (s_axi_araddr >= BUF_BASE && s_axi_araddr < 12'h548 &&
                      s_axi_araddr[1:0] == 2'h0));
    end
  end
  a_write_answer: assert property (disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  a_bvalid_release: assert property (disable iff (!aresetn)
    $fell(s_axi_bvalid) |-> $past(s_axi_bready)) else $error("bvalid dropped early");
  a_write_busy: assert property (disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_read_answer: assert property (disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid) else $error("read answer late");
  a_rvalid_release: assert property (disable iff (!aresetn)
    $fell(s_axi_rvalid) |-> $past(s_axi_rready)) else $error("rvalid dropped early");
  a_read_busy: assert property (disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_reset_quiet: assert property (!aresetn |=> !s_axi_bvalid && !s_axi_rvalid &&
    !rx_msg_irq && s_axi_arready) else $error("outputs active in reset");
  a_unmapped_error: assert property (disable iff (!aresetn) s_axi_rvalid && rd_bad_q
    |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_status_width: assert property (disable iff (!aresetn) s_axi_rvalid && rd_stat_q
    |-> s_axi_rdata[31:7] == 25'h0) else $error("status upper bits set");
  a_irq_cleared: assert property (disable iff (!aresetn) s_axi_rvalid && s_axi_rready &&
    rd_ctrl_q && s_axi_rdata[0] |-> ##[0:3] !rx_msg_irq) else $error("irq not cleared");
endmodule : e3lmr_rx_assertions
bind e3lmr_rx e3lmr_rx_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_msg_irq(rx_msg_irq));
`default_nettype wire

// [sim/e3lmr_lapd_tx.sv]
/*
  e3lmr_lapd_tx: behavioural far-end message transmitter on the N bit.
  Assumes the receiver's aclk; the strobe stands low between bits.
*/
`timescale 1ns/100ps
`default_nettype none
module e3lmr_lapd_tx
  import e3lmr_pkg::*;
(
  input  wire logic aclk,
  output var logic  n_bit,
  output var logic  n_strobe
);
  logic [2:0]  ones = 3'h0;
  logic [15:0] crc  = 16'h0000;
  initial n_bit = 1'b0;
  initial n_strobe = 1'b0;
  // one bit per strobe rise, held well past the receiver's synchroniser
  task automatic bit_out(input logic b);
    @(posedge aclk);
    n_bit <= b;
    repeat (4) @(posedge aclk);
    n_strobe <= 1'b1;
    repeat (4) @(posedge aclk);
    n_strobe <= 1'b0;
    n_bit <= ~b; // hold time over, so show the opposite level
  endtask : bit_out
  task automatic octet(input logic [7:0] o, input logic stuff);
    for (int i = 0; i < 8; i++)
    begin
      bit_out(o[i]); // least significant bit first
      ones = o[i] ? ones + 3'h1 : 3'h0;
      if (stuff && ones == 3'h5)
      begin
        bit_out(1'b0); // zero inserted after five ones
        ones = 3'h0;
      end
    end
  endtask : octet
  task automatic flag();
    ones = 3'h0;
    octet(FLAG_OCTET, 1'b0);
  endtask : flag
  task automatic abort_seq();
    repeat (8) bit_out(1'b1);
  endtask : abort_seq
  function automatic logic [7:0] pat(input int i);
    return (i % 3 == 0) ? 8'hFF : 8'(i * 7);
  endfunction : pat
  // crc msb first over each octet value, as the receiver checks it
  task automatic crc_add(input logic [7:0] o);
    for (int j = 7; j >= 0; j--)
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ o[j]) ? CRC_POLY : 16'h0000);
  endtask : crc_add
  // flag, address, endpoint, control, typed info, check hi/lo, flag
  task automatic frame(input logic [7:0] a0, input logic [7:0] ty, input int len,
                       input logic bad);
    logic [7:0] b;
    flag();
    crc = CRC_INIT;
    for (int i = -3; i < len; i++)
    begin
      b = i == -3 ? a0 : i == -2 ? 8'h01 : i == -1 ? 8'h03 : i == 0 ? ty : pat(i);
      crc_add(b);
      octet(b, 1'b1);
    end
    octet(crc[15:8], 1'b1);
    octet(crc[7:0] ^ {7'h00, bad}, 1'b1); // a bad check is injected only on request
    flag();
  endtask : frame
endmodule : e3lmr_lapd_tx
`default_nettype wire

// [sim/e3lmr_rx_tb_top.sv]
/*
  e3lmr_rx_tb_top: self-checking bench for the link message receiver.
  Assumes the far-end model and checker files are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module e3lmr_rx_tb_top
  import e3lmr_pkg::*;
;
  typedef struct packed {logic [7:0] a0; logic [7:0] ty; logic [7:0] len; logic bad;
                         logic [7:0] st;} e3lmr_row_t;
  localparam logic [11:0] CTRL_A = {CTRL_IDX, 2'b00};
  localparam logic [11:0] STAT_A = {STAT_IDX, 2'b00};
  logic [ADDR_W-1:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0]  bresp, rresp;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, n_bit, n_strobe;
  int          err_total = 0, total_checks = 0;
  e3lmr_row_t  rows [4] = '{'{8'h3C, TYPE_TEST, 8'h4C, 1'b0, 8'h03},
                            '{8'h3E, TYPE_IDLE, 8'h4C, 1'b1, 8'h1F},
                            '{8'h3C, TYPE_CL, 8'h4C, 1'b0, 8'h23},
                            '{8'h3E, TYPE_ITU, 8'h52, 1'b0, 8'h3B}};
  always #5 aclk = ~aclk;
  e3lmr_lapd_tx lapd (.aclk(aclk), .n_bit(n_bit), .n_strobe(n_strobe));
  e3lmr_rx dut (.aclk(aclk), .aresetn(aresetn), .rx_n_bit(n_bit), .rx_n_strobe(n_strobe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_msg_irq(irq));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one transfer; handshakes judged at the falling edge, acted on at the rising
  task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] v,
                     output logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tr, done;
    int n;
    @(posedge aclk);
    if (we)
    begin
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    else
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    done = 1'b0;
    for (n = 0; n < 64 && !done; n++)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      done = (bvalid && bready) || (rvalid && rready);
      d = rdata;
      r = we ? bresp : rresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (done) bready <= 1'b0;
      if (done) rready <= 1'b0;
    end
    if (!done)
    begin
      err_total++;
      finish_test();
    end
  endtask : bus
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    bus(1'b0, a, 32'h0000_0000, d, r);
    chk(d, e);
  endtask : rchk
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    bus(1'b1, a, v, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask : wr
  // rows: one frame each, then status, message flag, and stored bytes
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wr(CTRL_A, 32'h0000_0004, RESP_OKAY);
    foreach (rows[k])
    begin
      lapd.frame(rows[k].a0, rows[k].ty, int'(rows[k].len), rows[k].bad);
      repeat (8) @(posedge aclk);
      rchk(STAT_A, {24'h0, rows[k].st});
      rchk(CTRL_A, 32'h0000_0005);
      rchk(CTRL_A, 32'h0000_0004);
      rchk(BUF_BASE, {24'h0, rows[k].ty});
      rchk(BUF_BASE + 12'h004, {24'h0, lapd.pat(1)});
      rchk(BUF_BASE + 12'(4 * (rows[k].len - 1)), {24'h0, lapd.pat(rows[k].len - 1)});
    end
    // second reset mid-run: registers back to zero, receiver off
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(CTRL_A, {24'h0, CTRL_RESET});
    rchk(STAT_A, {24'h0, STAT_RESET});
    lapd.flag();
    repeat (8) @(posedge aclk);
    rchk(STAT_A, 32'h0000_0000);
    wr(CTRL_A, 32'h0000_0006, RESP_OKAY);
    lapd.flag();
    repeat (8) @(posedge aclk);
    rchk(STAT_A, 32'h0000_0001);
    lapd.frame(8'h3C, TYPE_CL, 76, 1'b0);
    repeat (8) @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0001);
    rchk(CTRL_A, 32'h0000_0007);
    chk({31'h0, irq}, 32'h0000_0000);
    // abort after a flag and one octet, before a frame opens: no completion, earlier results kept
    lapd.flag();
    lapd.octet(8'h3C, 1'b1);
    repeat (8) @(posedge aclk);
    rchk(STAT_A, 32'h0000_0022);
    lapd.abort_seq();
    repeat (8) @(posedge aclk);
    rchk(STAT_A, 32'h0000_0062);
    rchk(CTRL_A, 32'h0000_0006);
    wr(STAT_A, 32'h0000_00FF, RESP_OKAY);
    rchk(STAT_A, 32'h0000_0062);
    wr(12'h100, 32'h0000_0001, RESP_SLVERR);
    rchk(12'h100, 32'h0000_0000);
    finish_test();
  end
endmodule : e3lmr_rx_tb_top
`default_nettype wire
